/* File: core/twowire_status_core.sv */
`timescale 1ns/100ps
module twowire_status_core (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             irq,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    twowire_status_pkg::link_state_t st;
    logic [3:0]  bitcnt;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic [7:0]  tx_last;
    logic [7:0]  tx_data;
    logic        tx_fresh;
    logic        tx_empty_not_underflow;
    logic        addressed_as_target;
    logic        general_call_seen;
    logic        stop_seen;
    logic        rd_dir;
    logic        nack;
    logic        bus_busy;
    logic        sda_drv;
    logic [6:0]  own_addr;
    logic        module_run;
    logic        free_format_en;
    logic [15:0] irq_mask;
    logic [15:0] rdata;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    st:                     twowire_status_pkg::ST_IDLE,
    tx_empty_not_underflow: twowire_status_pkg::STATUS_RST[twowire_status_pkg::BIT_TX_EMPTY],
    own_addr:               twowire_status_pkg::OWN_ADDR_RST,
    irq_mask:               twowire_status_pkg::MASK_RST,
    default:                '0
  };

  core_state_t s_ff;
  core_state_t nxt;
  logic        line_sda;
  logic        line_rise;
  logic        line_fall;
  logic        line_start;
  logic        line_stop;
  logic        load_req;
  logic [2:0]  irq_code;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Status word as software sees it; bits seven and six stay zero
  function automatic logic [15:0] status_word(input core_state_t s);
    logic [15:0] r;
    r                                    = 16'h0000;
    r[twowire_status_pkg::BIT_TX_EMPTY]  = s.tx_empty_not_underflow;
    r[twowire_status_pkg::BIT_ADDRESSED] = s.addressed_as_target;
    r[twowire_status_pkg::BIT_GCALL]     = s.general_call_seen;
    r[twowire_status_pkg::BIT_STOP]      = s.stop_seen;
    return r;
  endfunction

  // Event view: underflow is the inverse of the empty flag
  function automatic logic [15:0] pending_word(input core_state_t s);
    logic [15:0] r;
    r                                   = status_word(s);
    r[twowire_status_pkg::BIT_TX_EMPTY] = !s.tx_empty_not_underflow;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Line monitor
  // ----------------------------------------------------------------
  twowire_line_monitor u_mon (
    .mclk      (mclk),
    .resetn    (resetn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_level (line_sda),
    .scl_rise  (line_rise),
    .scl_fall  (line_fall),
    .start_det (line_start),
    .stop_det  (line_stop)
  );

  // Source code: stop outranks address match, then underflow
  always_comb begin
    if (s_ff.stop_seen) begin
      irq_code = twowire_status_pkg::CODE_STOP;
    end else if (s_ff.addressed_as_target) begin
      irq_code = twowire_status_pkg::CODE_ADDRESSED;
    end else if (!s_ff.tx_empty_not_underflow) begin
      irq_code = twowire_status_pkg::CODE_UNDERFLOW;
    end else begin
      irq_code = twowire_status_pkg::CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] byte_out;
    logic       addr_match;
    logic       gcall;
    byte_out   = s_ff.tx_last;
    addr_match = 1'b0;
    gcall      = 1'b0;
    load_req   = 1'b0;
    nxt        = s_ff;
    nxt.rdata  = 16'h0000;
    // Bus side: bits sampled on clock rise, our data changes on clock fall
    case (s_ff.st)
      twowire_status_pkg::ST_ADDR, twowire_status_pkg::ST_RX: begin
        if (line_rise) begin
          nxt.rx_sh  = {s_ff.rx_sh[6:0], line_sda};
          nxt.bitcnt = s_ff.bitcnt + 4'h1;
        end else if (line_fall && s_ff.bitcnt == twowire_status_pkg::BITS_PER_BYTE) begin
          gcall      = s_ff.rx_sh[7:1] == twowire_status_pkg::GCALL_ADDR;
          addr_match = gcall || s_ff.rx_sh[7:1] == s_ff.own_addr;
          nxt.bitcnt = 4'h0;
          if (s_ff.st == twowire_status_pkg::ST_RX) begin
            nxt.st      = twowire_status_pkg::ST_ACK;
            nxt.sda_drv = 1'b1;
          end else if (s_ff.free_format_en) begin
            nxt.addressed_as_target = 1'b1;
            nxt.rd_dir              = 1'b0;
            nxt.st                  = twowire_status_pkg::ST_ACK;
            nxt.sda_drv             = 1'b1;
          end else if (addr_match) begin
            nxt.addressed_as_target = 1'b1;
            nxt.general_call_seen = gcall;
            nxt.rd_dir            = s_ff.rx_sh[0] && !gcall;
            nxt.st                = twowire_status_pkg::ST_ACK;
            nxt.sda_drv           = 1'b1;
          end else begin
            nxt.st = twowire_status_pkg::ST_IGNORE;
          end
        end
      end
      twowire_status_pkg::ST_ACK: begin
        if (line_rise) begin
          nxt.bitcnt = 4'h1;
        end else if (line_fall && s_ff.bitcnt == 4'h1) begin
          nxt.bitcnt  = 4'h0;
          nxt.sda_drv = 1'b0;
          load_req    = s_ff.rd_dir;
          nxt.st      = s_ff.rd_dir ? twowire_status_pkg::ST_TX : twowire_status_pkg::ST_RX;
        end
      end
      twowire_status_pkg::ST_TX: begin
        if (line_fall) begin
          if (s_ff.bitcnt == twowire_status_pkg::LAST_TX_BIT) begin
            nxt.st      = twowire_status_pkg::ST_TXACK;
            nxt.sda_drv = 1'b0;
            nxt.bitcnt  = 4'h0;
          end else begin
            nxt.tx_sh   = {s_ff.tx_sh[6:0], 1'b0};
            nxt.sda_drv = !s_ff.tx_sh[6];
            nxt.bitcnt  = s_ff.bitcnt + 4'h1;
          end
        end
      end
      twowire_status_pkg::ST_TXACK: begin
        if (line_rise) begin
          nxt.nack   = line_sda;
          nxt.bitcnt = 4'h1;
        end else if (line_fall && s_ff.bitcnt == 4'h1) begin
          nxt.bitcnt = 4'h0;
          load_req   = !s_ff.nack;
          nxt.st     = s_ff.nack ? twowire_status_pkg::ST_IGNORE : twowire_status_pkg::ST_TX;
        end
      end
      twowire_status_pkg::ST_IDLE, twowire_status_pkg::ST_IGNORE: begin
        nxt.sda_drv = 1'b0;
      end
      default: begin
        nxt.st      = twowire_status_pkg::ST_IDLE;
        nxt.sda_drv = 1'b0;
      end
    endcase
    // Shift register refill; an old byte goes out again if nothing new arrived
    if (load_req) begin
      if (s_ff.tx_fresh) begin
        byte_out     = s_ff.tx_data;
        nxt.tx_fresh = 1'b0;
      end else begin
        // shift register empty, no new data
        nxt.tx_empty_not_underflow = 1'b0;
      end
      // copy fresh data if any, else resend previous byte
      nxt.tx_sh   = byte_out;
      nxt.tx_last = byte_out;
      nxt.sda_drv = !byte_out[7];
    end
    // Bus framing overrides any bit activity in the same cycle
    if (line_start) begin
      nxt.st          = twowire_status_pkg::ST_ADDR;
      nxt.bitcnt      = 4'h0;
      nxt.sda_drv     = 1'b0;
      nxt.bus_busy    = 1'b1;
      nxt.general_call_seen = 1'b0;
      if (s_ff.bus_busy) begin
        nxt.addressed_as_target = 1'b0;
      end
    end
    if (line_stop) begin
      nxt.st                  = twowire_status_pkg::ST_IDLE;
      nxt.sda_drv             = 1'b0;
      nxt.bus_busy            = 1'b0;
      nxt.addressed_as_target = 1'b0;
      nxt.general_call_seen   = 1'b0;
      nxt.stop_seen           = 1'b1;
    end
    // Register writes; a stop in the same cycle beats the clear
    if (reg_wr) begin
      case (reg_addr)
        twowire_status_pkg::OFS_OWN_ADDR: nxt.own_addr = reg_wdata[6:0];
        twowire_status_pkg::OFS_IRQ_MASK:
          nxt.irq_mask = reg_wdata & twowire_status_pkg::MASK_VALID;
        twowire_status_pkg::OFS_STATUS: begin
          // write one clears stop flag; other bits ignored
          if (reg_wdata[twowire_status_pkg::BIT_STOP] && !line_stop) begin
            nxt.stop_seen = 1'b0;
          end
        end
        twowire_status_pkg::OFS_TX_DATA: begin
          nxt.tx_data                = reg_wdata[7:0];
          nxt.tx_fresh               = 1'b1;
          nxt.tx_empty_not_underflow = 1'b1;
        end
        twowire_status_pkg::OFS_MODE: begin
          nxt.module_run     = reg_wdata[twowire_status_pkg::BIT_RUN];
          nxt.free_format_en = reg_wdata[twowire_status_pkg::BIT_FREE_FMT];
        end
        default: begin
        end
      endcase
    end
    // Register reads; data valid in the next cycle only
    if (reg_rd) begin
      case (reg_addr)
        twowire_status_pkg::OFS_OWN_ADDR: nxt.rdata = {9'h000, s_ff.own_addr};
        twowire_status_pkg::OFS_IRQ_MASK: nxt.rdata = s_ff.irq_mask;
        twowire_status_pkg::OFS_STATUS:   nxt.rdata = status_word(s_ff);
        twowire_status_pkg::OFS_TX_DATA:  nxt.rdata = {8'h00, s_ff.tx_data};
        twowire_status_pkg::OFS_MODE: begin
          nxt.rdata[twowire_status_pkg::BIT_RUN]      = s_ff.module_run;
          nxt.rdata[twowire_status_pkg::BIT_FREE_FMT] = s_ff.free_format_en;
        end
        twowire_status_pkg::OFS_IRQ_SRC: begin
          nxt.rdata = {13'h0000, irq_code};
          if (irq_code == twowire_status_pkg::CODE_STOP && !line_stop) begin
            nxt.stop_seen = 1'b0;
          end
        end
        default: nxt.rdata = 16'h0000;
      endcase
    end
    // module held in reset while run is low
    if (!nxt.module_run) begin
      nxt.st                     = twowire_status_pkg::ST_IDLE;
      nxt.bitcnt                 = 4'h0;
      nxt.sda_drv                = 1'b0;
      nxt.bus_busy               = 1'b0;
      nxt.tx_fresh               = 1'b0;
      nxt.tx_empty_not_underflow = 1'b1;
      nxt.addressed_as_target    = 1'b0;
      nxt.general_call_seen      = 1'b0;
      nxt.stop_seen              = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_ff <= CORE_RST;
    end else begin
      s_ff <= nxt;
    end
  end

  // Open-drain data pin: only ever pulls low
  assign sda_out   = 1'b0;
  assign sda_oe    = s_ff.sda_drv;
  assign reg_rdata = s_ff.rdata;
  assign irq       = |(pending_word(s_ff) & s_ff.irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_code_read;
    reg_rd && reg_addr == twowire_status_pkg::OFS_IRQ_SRC
      && irq_code == twowire_status_pkg::CODE_STOP;
  endsequence
  sequence s_stale_load;
    load_req && !s_ff.tx_fresh;
  endsequence
  sequence s_quiet_write;
    !line_stop && s_ff.module_run;
  endsequence
  // A run-low write in the same cycle legally forces the flag back to one
  a_underflow_flag: assert property (
    s_stale_load ##0 !(reg_wr && reg_addr == twowire_status_pkg::OFS_TX_DATA)
      |=> !s_ff.tx_empty_not_underflow || !s_ff.module_run)
    else $error("underflow not flagged on stale load");
  a_resend_prev: assert property (
    s_stale_load |=> s_ff.tx_sh == $past(s_ff.tx_last) || !s_ff.module_run)
    else $error("previous byte not resent");
  a_write_sets_empty: assert property (
    reg_wr && reg_addr == twowire_status_pkg::OFS_TX_DATA |=> s_ff.tx_empty_not_underflow)
    else $error("tx write did not set empty flag");
  a_run_low_reset: assert property (
    !s_ff.module_run |-> s_ff.tx_empty_not_underflow && !s_ff.addressed_as_target
      && !s_ff.general_call_seen && !s_ff.stop_seen)
    else $error("flags not reset while run low");
  a_gcall_source: assert property (
    $rose(s_ff.general_call_seen) |-> $past(s_ff.rx_sh[7:1]) == twowire_status_pkg::GCALL_ADDR
      && s_ff.addressed_as_target && s_ff.sda_drv)
    else $error("general call flag without zero address");
  a_stop_clears_aas: assert property (
    line_stop |=> !s_ff.addressed_as_target && !s_ff.general_call_seen)
    else $error("stop did not clear address flags");
  a_start_clears_gc: assert property (
    line_start |=> !s_ff.general_call_seen)
    else $error("start did not clear general call");
  // Only the status word is checked here; tx data uses bits seven and six, own address uses bit six
  a_reserved_zero: assert property (
    reg_rd && reg_addr == twowire_status_pkg::OFS_STATUS |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved status bits not zero");
  a_stop_sets: assert property (
    line_stop && s_ff.module_run && !(reg_wr && reg_addr == twowire_status_pkg::OFS_MODE)
      ##1 !reg_wr && !reg_rd |-> s_ff.stop_seen [*2])
    else $error("stop flag not set and held");
  a_code_read_clr: assert property (
    s_code_read ##0 s_quiet_write
      |=> !s_ff.stop_seen && reg_rdata[2:0] == twowire_status_pkg::CODE_STOP)
    else $error("stop code read did not clear flag");
  a_w1c_stop: assert property (
    reg_wr && reg_addr == twowire_status_pkg::OFS_STATUS
      && reg_wdata[twowire_status_pkg::BIT_STOP] ##0 s_quiet_write |=> !s_ff.stop_seen)
    else $error("write one did not clear stop flag");
endmodule

/* File: inc/twowire_status_pkg.sv */
// Functional notes
// - Flag tx_empty_not_underflow drops to 0 when shift register empties without a new write.
// - No new copy until tx data is written; the previous byte is resent meanwhile.
// - Writing tx data, or module reset (run low, chip reset), sets the flag to 1.
// - Own target address or general call address sets addressed_as_target.
// - In free format mode, addressed_as_target sets after the first data word.
// - Repeated START or STOP clears addressed_as_target.
// - An all-zero address sets general_call_seen.
// - Any START or STOP clears general_call_seen.
// - Status bits seven and six read as zero; writes to them do nothing.
// - Any STOP on the bus sets stop_seen, whoever generated it; the code holds it at 0 while run is low.
// - Reading the stop code from the interrupt source field clears stop_seen.
// - Writing a one to the stop_seen bit clears it.
package twowire_status_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_OWN_ADDR = 8'h00;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_TX_DATA  = 8'h20;
  localparam logic [7:0]  OFS_MODE     = 8'h24;
  localparam logic [7:0]  OFS_IRQ_SRC  = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          BIT_TX_EMPTY  = 10;
  localparam int          BIT_ADDRESSED = 9;
  localparam int          BIT_GCALL     = 8;
  localparam int          BIT_STOP      = 5;
  localparam int          BIT_RUN       = 5;
  localparam int          BIT_FREE_FMT  = 3;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] STATUS_RST    = 16'h0400;
  localparam logic [15:0] MASK_RST      = 16'h0000;
  localparam logic [15:0] MASK_VALID    = 16'h0720;
  localparam logic [6:0]  OWN_ADDR_RST  = 7'h2A;
  localparam logic [6:0]  GCALL_ADDR    = 7'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;

  // ----------------------------------------------------------------
  // Interrupt source codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  CODE_NONE      = 3'h0;
  localparam logic [2:0]  CODE_UNDERFLOW = 3'h5;
  localparam logic [2:0]  CODE_STOP      = 3'h6;
  localparam logic [2:0]  CODE_ADDRESSED = 3'h7;

  // ----------------------------------------------------------------
  // Link states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_RX     = 3'b011,
    ST_TX     = 3'b100,
    ST_TXACK  = 3'b101,
    ST_IGNORE = 3'b110
  } link_state_t;

endpackage

/* File: core/twowire_line_monitor.sv */
`timescale 1ns/100ps
module twowire_line_monitor (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_level,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
  } mon_state_t;

  localparam mon_state_t MON_RST = '{scl_sync: 3'h7, sda_sync: 3'h7, scl_q: 1'b1,
                                     sda_q: 1'b1, default: 1'b0};

  mon_state_t mon_ff;
  mon_state_t nxt_mon;

  // Level changes only once stages two and three agree; stage one feeds stage two only
  always_comb begin
    logic scl_new;
    logic sda_new;
    nxt_mon          = mon_ff;
    scl_new          = mon_ff.scl_q;
    sda_new          = mon_ff.sda_q;
    nxt_mon.scl_sync = {mon_ff.scl_sync[1:0], scl_in};
    nxt_mon.sda_sync = {mon_ff.sda_sync[1:0], sda_in};
    if (mon_ff.scl_sync[1] == mon_ff.scl_sync[2]) begin
      scl_new = mon_ff.scl_sync[2];
    end
    if (mon_ff.sda_sync[1] == mon_ff.sda_sync[2]) begin
      sda_new = mon_ff.sda_sync[2];
    end
    nxt_mon.scl_q = scl_new;
    nxt_mon.sda_q = sda_new;
    nxt_mon.rise  = scl_new && !mon_ff.scl_q;
    nxt_mon.fall  = !scl_new && mon_ff.scl_q;
    // Data edges while the clock stays high frame a transfer
    nxt_mon.start = mon_ff.scl_q && scl_new && mon_ff.sda_q && !sda_new;
    nxt_mon.stop  = mon_ff.scl_q && scl_new && !mon_ff.sda_q && sda_new;
  end

  // Register the whole monitor state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mon_ff <= MON_RST;
    end else begin
      mon_ff <= nxt_mon;
    end
  end

  assign sda_level = mon_ff.sda_q;
  assign scl_rise  = mon_ff.rise;
  assign scl_fall  = mon_ff.fall;
  assign start_det = mon_ff.start;
  assign stop_det  = mon_ff.stop;

endmodule

/* File: testbench/twowire_master_model.sv */
`timescale 1ns/100ps
module twowire_master_model #(
  parameter int HALF = 10
) (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_o,
  output logic      sda_pull
);
  // Idle bus: both lines released and pulled high, so the clock stands still between frames
  initial begin
    scl_o    = 1'b1;
    sda_pull = 1'b0;
  end

  // All line changes land by non-blocking assignment just after an mclk edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // START from idle or as a repeated START while SCL is low
  task automatic start();
    tick(HALF / 2);
    sda_pull <= 1'b0;
    tick(HALF / 2);
    scl_o    <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl_o    <= 1'b0;
  endtask

  // STOP: data rises while the clock is high
  task automatic stop();
    tick(HALF / 2);
    sda_pull <= 1'b1;
    tick(HALF / 2);
    scl_o    <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask

  // One bit cell; data changes mid-low so the target's sync chain sees it settled
  task automatic bit_cell(input logic b, output logic r);
    tick(HALF / 2);
    sda_pull <= !b;
    tick(HALF / 2);
    scl_o    <= 1'b1;
    tick(HALF);
    r = sda_line;
    scl_o    <= 1'b0;
  endtask

  // Byte out, MSB first, then the target's acknowledge slot
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(v[i], r);
    end
    bit_cell(1'b1, r);
    ack = !r;
  endtask

  // Byte in from the target, then our acknowledge (1 = no acknowledge)
  task automatic rbyte(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(1'b1, r);
      v[i] = r;
    end
    bit_cell(nack, r);
  endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  typedef struct {
    logic [7:0]  a;
    logic [15:0] e;
  } row_t;

  logic        mclk         = 1'b0;
  logic        resetn       = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [15:0] reg_wdata    = 16'h0000;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [15:0] reg_rdata;
  logic        irq;
  logic        scl;
  logic        sda_pull;
  logic        sda_out;
  logic        sda_oe;
  logic        ack;
  logic [7:0]  rx;
  int          error_cnt    = 0;
  int          total_checks = 0;
  row_t        rows [6]     = '{'{8'h08, 16'h0400}, '{8'h04, 16'h0000}, '{8'h00, 16'h002A},
                                '{8'h28, 16'h0000}, '{8'h24, 16'h0000}, '{8'h10, 16'h0000}};
  // Open-drain data line: any party pulling wins, pull-up otherwise
  wire         sda_line     = (sda_oe ? sda_out : 1'b1) & !sda_pull;

  twowire_status_core dut_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
  twowire_master_model #(.HALF(10)) bm_u (.mclk(mclk), .sda_line(sda_line), .scl_o(scl),
    .sda_pull(sda_pull));

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[i]) rd(rows[i].a, rows[i].e);
    wr(8'h04, 16'h0720);
    wr(8'h24, 16'h0020);
    // Own address write, one data byte, then STOP
    bm_u.start();
    bm_u.wbyte(8'h54, ack);
    chk({15'h0, ack}, 16'h0001);
    rd(8'h08, 16'h0600);
    bm_u.wbyte(8'h3C, ack);
    bm_u.stop();
    rd(8'h08, 16'h0420);
    chk({15'h0, irq}, 16'h0001);
    rd(8'h28, 16'h0006);
    rd(8'h08, 16'h0400);
    chk({15'h0, irq}, 16'h0000);
    // General call, cut short by a repeated START, then a foreign address
    bm_u.start();
    bm_u.wbyte(8'h00, ack);
    rd(8'h08, 16'h0700);
    bm_u.start();
    rd(8'h08, 16'h0400);
    bm_u.wbyte(8'h22, ack);
    chk({15'h0, ack}, 16'h0000);
    bm_u.stop();
    wr(8'h08, 16'h00C0);
    rd(8'h08, 16'h0420);
    wr(8'h04, 16'h0000);
    #1 chk({15'h0, irq}, 16'h0000);
    wr(8'h04, 16'h0720);
    wr(8'h08, 16'h0020);
    rd(8'h08, 16'h0400);
    // Read transfer: second byte has no fresh data and is resent
    wr(8'h20, 16'h00A5);
    bm_u.start();
    bm_u.wbyte(8'h55, ack);
    bm_u.rbyte(1'b0, rx);
    chk({8'h00, rx}, 16'h00A5);
    // The stale reload lands some cycles after the ninth clock fall
    repeat (8) @(posedge mclk);
    rd(8'h08, 16'h0200);
    rd(8'h28, 16'h0007);
    bm_u.rbyte(1'b1, rx);
    chk({8'h00, rx}, 16'h00A5);
    bm_u.stop();
    rd(8'h08, 16'h0020);
    chk({15'h0, irq}, 16'h0001);
    wr(8'h20, 16'h005A);
    rd(8'h08, 16'h0420);
    wr(8'h24, 16'h0000);
    rd(8'h08, 16'h0400);
    // Held in module reset the bus is ignored
    bm_u.start();
    bm_u.wbyte(8'h54, ack);
    bm_u.stop();
    chk({15'h0, ack}, 16'h0000);
    rd(8'h08, 16'h0400);
    // Free format: first byte is data
    wr(8'h24, 16'h0028);
    bm_u.start();
    bm_u.wbyte(8'h13, ack);
    rd(8'h08, 16'h0600);
    bm_u.stop();
    // Chip reset in mid-run with flags set
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(8'h08, 16'h0400);
    rd(8'h24, 16'h0000);
    tally_and_finish();
  end
endmodule
